// file: hw/cfp_pkg.sv
// package: constants of the chroma format path
package cfp_pkg;
  localparam int CFP_CW = 12;
  localparam int CFP_PW = 36;
  localparam logic [7:0] CFP_OFS_UP = 8'h1d;
  localparam logic [7:0] CFP_OFS_CS = 8'h53;
  localparam logic [7:0] CFP_OFS_BYP = 8'hbd;
  localparam logic [7:0] CFP_OFS_SKIP = 8'he0;
  localparam int CFP_BIT_UP = 5;
  localparam int CFP_BIT_BYP = 4;
  localparam int CFP_BIT_SKIP = 7;
  localparam logic CFP_RST_UP = 1'b0;
  localparam logic CFP_RST_BYP = 1'b1;
  localparam logic CFP_RST_SKIP = 1'b0;
  localparam logic [3:0] CFP_RST_CS = 4'h0;
  // input sample width codes
  localparam logic [1:0] CFP_W8 = 2'h0;
  localparam logic [1:0] CFP_W10 = 2'h1;
  localparam logic [1:0] CFP_W12 = 2'h2;
  // colour space codes
  localparam logic [3:0] CFP_CS_RGB_LIM = 4'h0;
  localparam logic [3:0] CFP_CS_RGB_FULL = 4'h1;
  localparam logic [3:0] CFP_CS_601 = 4'h2;
  localparam logic [3:0] CFP_CS_709 = 4'h3;
  localparam logic [3:0] CFP_CS_XV601 = 4'h4;
  localparam logic [3:0] CFP_CS_XV709 = 4'h5;
  localparam logic [3:0] CFP_CS_601F = 4'h6;
  localparam logic [3:0] CFP_CS_709F = 4'h7;
  localparam logic [3:0] CFP_CS_SY601 = 4'h8;
  localparam logic [3:0] CFP_CS_AYCC = 4'h9;
  localparam logic [3:0] CFP_CS_ARGB = 4'ha;
  localparam int CFP_LAT = 2;
endpackage

// file: hw/cfp_chroma_path.sv
// chroma format path: left-justify, upconvert, filter and downsample
`timescale 1ns/10ps
// Summary of operation
// - video toward the preprocessor is 36 bits per pixel, 4:2:2 when i_out_422 is set, else 4:4:4
// - 4:4:4 input is forwarded with no upconversion; only a 4:2:2 output downsamples it
// - 4:2:2 input is upconverted to 4:4:4 by the upsample select method
// - narrow components are left-justified, low bits filled with zeros
// - upsample select at 0x1D bit 5, reset 0: 0 repeats, 1 interpolates
// - 4:2:2 output downconverts, filtered or not per filter-skip
// - 4:4:4 input: skip 0 filters then downsamples, 1 only downsamples
// - 4:2:2 input: skip sense inverted, default leaves it unfiltered
// - skip disables only chroma filters on B and C, downsampler keeps working
// - bypass at 0xBD bit 4, reset 1: 1 bypasses, 0 enables
// - pass-through disables only the chroma filters; upconversion and downsampling still run
// - colour space comes from link mode and decoded AVI frame
// - colour code read-only at 0x53 bits 3:0, reset 0000, values 0-1010
module cfp_chroma_path
  import cfp_pkg::*;
#(
  parameter int CW = CFP_CW
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rd_data,
  // input video, three right-aligned lanes a, b, c
  input wire logic i_vid_valid,
  input wire logic [3*CW-1:0] i_vid_data,
  input wire logic [1:0] i_in_width,
  input wire logic i_in_422,
  input wire logic i_out_422,
  // link status and decoded AVI fields
  input wire logic i_dvi_mode,
  input wire logic i_avi_valid,
  input wire logic [1:0] i_avi_y,
  input wire logic [1:0] i_avi_c,
  input wire logic [2:0] i_avi_ec,
  input wire logic [1:0] i_avi_q,
  input wire logic [1:0] i_avi_yq,
  // output video and colour space
  output logic o_vid_valid,
  output logic [3*CW-1:0] o_vid_data,
  output logic [3:0] o_cs_code
);

  function automatic logic [CW-1:0] lj(input logic [CW-1:0] v, input logic [1:0] w);
    lj = v;
    if (w == CFP_W8) begin
      lj = {v[CW-5:0], 4'h0};
    end else if (w == CFP_W10) begin
      lj = {v[CW-3:0], 2'h0};
    end
  endfunction

  function automatic logic [CW-1:0] avg(input logic [CW-1:0] a, input logic [CW-1:0] b);
    logic [CW:0] s;
    s = {1'b0, a} + {1'b0, b};
    avg = s[CW:1];
  endfunction

  function automatic logic [3:0] cs_map(input logic [1:0] y, input logic [1:0] c,
                                        input logic [2:0] ec, input logic [1:0] q,
                                        input logic [1:0] yq);
    cs_map = CFP_CS_RGB_LIM;
    if (y == 2'h0) begin
      if (c == 2'h3 && ec == 3'h4) begin
        cs_map = CFP_CS_ARGB;
      end else if (q == 2'h2) begin
        cs_map = CFP_CS_RGB_FULL;
      end
    end else if (c == 2'h3) begin
      case (ec)
        3'h0: cs_map = CFP_CS_XV601;
        3'h1: cs_map = CFP_CS_XV709;
        3'h2: cs_map = CFP_CS_SY601;
        3'h3: cs_map = CFP_CS_AYCC;
        default: cs_map = CFP_CS_601;
      endcase
    end else if (c == 2'h2) begin
      cs_map = (yq == 2'h1) ? CFP_CS_709F : CFP_CS_709;
    end else begin
      cs_map = (yq == 2'h1) ? CFP_CS_601F : CFP_CS_601;
    end
  endfunction

  // control bits
  logic up_interp_ff;
  logic bypass_ff;
  logic skip_ff;
  logic [3:0] cs_ff;
  logic avi_seen_ff;
  // stage 1: upconverted 4:4:4
  logic ph_ff;
  logic [CW-1:0] cb_ff;
  logic [CW-1:0] cr_ff;
  logic u_valid_ff;
  logic u_in422_ff;
  logic [CW-1:0] u_a_ff;
  logic [CW-1:0] u_b_ff;
  logic [CW-1:0] u_c_ff;
  // stage 2: output
  logic oph_ff;
  logic [CW-1:0] pb_ff;
  logic [CW-1:0] pc_ff;

  // register decode
  wire hit_up = i_addr == CFP_OFS_UP;
  wire hit_cs = i_addr == CFP_OFS_CS;
  wire hit_byp = i_addr == CFP_OFS_BYP;
  wire hit_skip = i_addr == CFP_OFS_SKIP;
  wire [7:0] rd_up = 8'(up_interp_ff) << CFP_BIT_UP;
  wire [7:0] rd_byp = 8'(bypass_ff) << CFP_BIT_BYP;
  wire [7:0] rd_skip = 8'(skip_ff) << CFP_BIT_SKIP;
  wire [7:0] rd_cs = {4'h0, cs_ff};
  wire [7:0] rd_mux = hit_up ? rd_up : hit_byp ? rd_byp :
                      hit_skip ? rd_skip : hit_cs ? rd_cs : 8'h00;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      up_interp_ff <= CFP_RST_UP;
      bypass_ff <= CFP_RST_BYP;
      skip_ff <= CFP_RST_SKIP;
      o_rd_data <= 8'h00;
    end else begin
      if (i_wr && hit_up) begin
        up_interp_ff <= i_wr_data[CFP_BIT_UP];
      end
      if (i_wr && hit_byp) begin
        bypass_ff <= i_wr_data[CFP_BIT_BYP];
      end
      if (i_wr && hit_skip) begin
        skip_ff <= i_wr_data[CFP_BIT_SKIP];
      end
      // read data stands one cycle only; colour code is read-only
      o_rd_data <= i_rd ? rd_mux : 8'h00;
    end
  end

  // colour space: dvi link or no frame yet reports the reset code
  wire [3:0] nxt_cs = i_dvi_mode ? CFP_CS_RGB_LIM :
                      (i_avi_valid ? cs_map(i_avi_y, i_avi_c, i_avi_ec, i_avi_q, i_avi_yq)
                       : cs_ff);
  wire nxt_avi_seen = !i_dvi_mode && (avi_seen_ff || i_avi_valid);

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      cs_ff <= CFP_RST_CS;
      avi_seen_ff <= 1'b0;
      o_cs_code <= CFP_RST_CS;
    end else begin
      cs_ff <= nxt_cs;
      avi_seen_ff <= nxt_avi_seen;
      o_cs_code <= nxt_cs;
    end
  end

  // stage 1: left-justify, then upconvert 4:2:2
  wire [CW-1:0] in_a = lj(i_vid_data[3*CW-1:2*CW], i_in_width);
  wire [CW-1:0] in_b = lj(i_vid_data[2*CW-1:CW], i_in_width);
  wire [CW-1:0] in_c = lj(i_vid_data[CW-1:0], i_in_width);
  // even 4:2:2 pixels carry cb in lane b, odd ones cr
  wire [CW-1:0] nxt_cb = ph_ff ? cb_ff : in_b;
  wire [CW-1:0] nxt_cr = ph_ff ? in_b : cr_ff;
  // causal interpolation: midpoint of the last two samples, no look-ahead
  wire [CW-1:0] up_b = up_interp_ff ? avg(cb_ff, nxt_cb) : nxt_cb;
  wire [CW-1:0] up_c = up_interp_ff ? avg(cr_ff, nxt_cr) : nxt_cr;
  wire [CW-1:0] nxt_u_b = i_in_422 ? up_b : in_b;
  wire [CW-1:0] nxt_u_c = i_in_422 ? up_c : in_c;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      ph_ff <= 1'b0;
      cb_ff <= '0;
      cr_ff <= '0;
      u_valid_ff <= 1'b0;
      u_in422_ff <= 1'b0;
      u_a_ff <= '0;
      u_b_ff <= '0;
      u_c_ff <= '0;
    end else begin
      u_valid_ff <= i_vid_valid;
      if (!i_in_422) begin
        ph_ff <= 1'b0;
      end else if (i_vid_valid) begin
        ph_ff <= !ph_ff;
        cb_ff <= nxt_cb;
        cr_ff <= nxt_cr;
      end
      if (i_vid_valid) begin
        u_in422_ff <= i_in_422;
        u_a_ff <= in_a;
        u_b_ff <= nxt_u_b;
        u_c_ff <= nxt_u_c;
      end
    end
  end

  // stage 2: optional chroma filter, downsample for 4:2:2 output
  wire inv_skip = u_in422_ff ? skip_ff : !skip_ff;
  wire do_filt = !bypass_ff && i_out_422 && inv_skip;
  wire [CW-1:0] f_b = do_filt ? avg(pb_ff, u_b_ff) : u_b_ff;
  wire [CW-1:0] f_c = do_filt ? avg(pc_ff, u_c_ff) : u_c_ff;
  // downsampler runs whether or not filters are on
  wire [CW-1:0] ds_b = oph_ff ? f_c : f_b;
  wire [3*CW-1:0] nxt_out = i_out_422 ? {u_a_ff, ds_b, {CW{1'b0}}}
                                      : {u_a_ff, u_b_ff, u_c_ff};

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      oph_ff <= 1'b0;
      pb_ff <= '0;
      pc_ff <= '0;
      o_vid_valid <= 1'b0;
      o_vid_data <= '0;
    end else begin
      o_vid_valid <= u_valid_ff;
      if (!i_out_422) begin
        oph_ff <= 1'b0;
      end else if (u_valid_ff) begin
        oph_ff <= !oph_ff;
      end
      if (u_valid_ff) begin
        pb_ff <= u_b_ff;
        pc_ff <= u_c_ff;
        o_vid_data <= nxt_out;
      end
    end
  end

  default clocking cb_chk @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);

  chk_valid_lat: assert property (i_vid_valid |-> ##2 o_vid_valid)
    else $error("output valid not two cycles after input");
  chk_fwd_444: assert property (i_vid_valid && !i_in_422 |=> u_b_ff == $past(in_b)
                                && u_c_ff == $past(in_c))
    else $error("4:4:4 chroma altered in stage 1");
  chk_left_just: assert property (i_vid_valid && i_in_width == CFP_W8
                                  |=> u_a_ff[3:0] == 4'h0)
    else $error("8-bit sample not left-justified");
  chk_up_repeat: assert property (i_vid_valid && i_in_422 && !up_interp_ff && ph_ff
                                  |=> u_c_ff == $past(in_b) && u_b_ff == $past(cb_ff))
    else $error("repeat upconversion wrong");
  chk_up_interp: assert property (i_vid_valid && i_in_422 && up_interp_ff && !ph_ff
                                  |=> u_b_ff == avg($past(cb_ff), $past(in_b)))
    else $error("interpolated chroma wrong");
  chk_filt_sense: assert property (u_valid_ff && i_out_422 && !bypass_ff && u_in422_ff
                                   && !skip_ff && !oph_ff
                                   |=> o_vid_data[2*CW-1:CW] == $past(u_b_ff))
    else $error("default skip filtered 4:2:2 input");
  chk_bypass_raw: assert property (u_valid_ff && bypass_ff && !i_out_422
                                   |=> o_vid_data == $past({u_a_ff, u_b_ff, u_c_ff}))
    else $error("bypass altered samples");
  chk_ds_zero_c: assert property (u_valid_ff && i_out_422
                                  |=> o_vid_data[CW-1:0] == '0)
    else $error("downsampled lane c not cleared");
  chk_cs_range: assert property (o_cs_code <= CFP_CS_ARGB)
    else $error("undefined colour code reported");
  chk_cs_dvi: assert property (i_dvi_mode |=> o_cs_code == CFP_CS_RGB_LIM && !avi_seen_ff)
    else $error("dvi link did not force reset code");
  chk_cs_rd: assert property (i_rd && hit_cs |=> o_rd_data == {4'h0, $past(cs_ff)})
    else $error("colour code readback wrong");
  // readback stands one cycle; the code only moves on a frame or a dvi link
  chk_rd_idle: assert property (!i_rd |=> o_rd_data == 8'h00)
    else $error("read data present without a read");
  chk_cs_hold: assert property (!i_dvi_mode && !i_avi_valid |=> $stable(o_cs_code))
    else $error("colour code changed without a frame");
  chk_cs_frame: assert property (!i_dvi_mode && i_avi_valid && i_avi_y == 2'h0
                                 && i_avi_q == 2'h2 && !(i_avi_c == 2'h3 && i_avi_ec == 3'h4)
                                 |=> o_cs_code == CFP_CS_RGB_FULL)
    else $error("full range rgb frame not reported");
  chk_byp_nofilt: assert property (u_valid_ff && bypass_ff && i_out_422 && !oph_ff
                                   |=> o_vid_data[2*CW-1:CW] == $past(u_b_ff))
    else $error("bypass filtered chroma");
  chk_skip_444: assert property (u_valid_ff && i_out_422 && !bypass_ff && !u_in422_ff
                                 && skip_ff && oph_ff
                                 |=> o_vid_data[2*CW-1:CW] == $past(u_c_ff))
    else $error("skip set but 4:4:4 chroma filtered");
  chk_filt_444: assert property (u_valid_ff && i_out_422 && !bypass_ff && !u_in422_ff
                                 && !skip_ff && !oph_ff
                                 |=> o_vid_data[2*CW-1:CW] == avg($past(pb_ff), $past(u_b_ff)))
    else $error("4:4:4 chroma not filtered before downsampling");
  chk_byp_write: assert property (i_wr && hit_byp
                                  |=> bypass_ff == $past(i_wr_data[CFP_BIT_BYP]))
    else $error("bypass bit write lost");

  cov_up_422: cover property (i_vid_valid && i_in_422 ##1 i_vid_valid && i_in_422);
  cov_filt_on: cover property (u_valid_ff && do_filt);
  cov_bypass_422: cover property (u_valid_ff && bypass_ff && i_out_422);
  cov_cs_xv: cover property (o_cs_code == CFP_CS_XV709);
  cov_interp_422: cover property (u_valid_ff && u_in422_ff && up_interp_ff);

endmodule // cfp_chroma_path

// file: sim/cfp_sink.sv
// downstream processor model: collects every pixel the path hands on
`timescale 1ns/10ps
module cfp_sink
  import cfp_pkg::*;
(
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // pixel stream from the path, no back-pressure exists
  input wire logic i_valid,
  input wire logic [CFP_PW-1:0] i_data
);
  logic [CFP_PW-1:0] got[$];
  // takes every valid cycle, as the real stage cannot stall
  always @(posedge i_core_clk) begin
    if (!i_rst && i_valid === 1'b1) begin
      got.push_back(i_data);
    end
  end
endmodule // cfp_sink

// file: sim/tb_rx_video_chroma_format_path.sv
// testbench of the chroma format path against a behavioural reference
`timescale 1ns/10ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
  $display("unexpected %s expected %h seen %h", n, e, g); end end
module tb_rx_video_chroma_format_path;
  import cfp_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_wr = 1'b0, i_rd = 1'b0, i_vid_valid = 1'b0, i_in_422 = 1'b0, i_out_422 = 1'b0;
  logic i_dvi_mode = 1'b0, i_avi_valid = 1'b0;
  logic [7:0] i_addr = '0, i_wr_data = '0, o_rd_data;
  logic [1:0] i_in_width = '0, i_avi_y = '0, i_avi_c = '0, i_avi_q = '0, i_avi_yq = '0;
  logic [2:0] i_avi_ec = '0;
  logic [35:0] i_vid_data = '0, o_vid_data;
  logic o_vid_valid;
  logic [3:0] o_cs_code;
  int fail_count = 0, samples_checked = 0;
  int cb, cr, pcb, pcr, pb, pc, ph, oph;
  logic [35:0] exp_q[$];
  bit chk_q[$];
  logic [7:0] ofs[5] = '{CFP_OFS_UP, CFP_OFS_BYP, CFP_OFS_SKIP, CFP_OFS_CS, 8'h54};
  logic [7:0] keep[5] = '{8'h20, 8'h10, 8'h80, 8'h00, 8'h00};

  cfp_chroma_path u_cfp_chroma_path (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data),
    .i_vid_valid(i_vid_valid), .i_vid_data(i_vid_data), .i_in_width(i_in_width),
    .i_in_422(i_in_422), .i_out_422(i_out_422), .i_dvi_mode(i_dvi_mode),
    .i_avi_valid(i_avi_valid), .i_avi_y(i_avi_y), .i_avi_c(i_avi_c), .i_avi_ec(i_avi_ec),
    .i_avi_q(i_avi_q), .i_avi_yq(i_avi_yq), .o_vid_valid(o_vid_valid),
    .o_vid_data(o_vid_data), .o_cs_code(o_cs_code));
  cfp_sink u_cfp_sink (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_valid(o_vid_valid),
    .i_data(o_vid_data));

  initial begin
    forever #50 i_core_clk = ~i_core_clk;
  end

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wr_data <= d;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_core_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1;
    `CHK("o_rd_data", e, o_rd_data);
  endtask

  // reference per pixel; history is unknown early in a run, so those are not judged
  task automatic pix(input int w, up, byp, skp, i422, o422, n);
    int la, lb, lc, sh, sb, sc, fb, fc, ob, f;
    sh = (w == 0) ? 4 : (w == 1) ? 2 : 0;
    la = $urandom & ((1 << (12 - sh)) - 1);
    lb = $urandom & ((1 << (12 - sh)) - 1);
    lc = $urandom & ((1 << (12 - sh)) - 1);
    if ($urandom_range(3) == 0) begin
      @(posedge i_core_clk);
      i_vid_valid <= 1'b0;
    end
    @(posedge i_core_clk);
    i_vid_valid <= 1'b1;
    i_vid_data <= {la[11:0], lb[11:0], lc[11:0]};
    i_in_width <= w[1:0];
    la = la << sh;
    lb = lb << sh;
    lc = lc << sh;
    sb = lb;
    sc = lc;
    if (i422 != 0) begin
      // causal: the channel without a new sample repeats its latest value
      if (ph == 0) {pcb, cb, pcr} = {cb, lb, cr};
      else {pcr, cr, pcb} = {cr, lb, cb};
      ph = 1 - ph;
      sb = (up != 0) ? (pcb + cb) / 2 : cb;
      sc = (up != 0) ? (pcr + cr) / 2 : cr;
    end
    f = (byp == 0 && o422 != 0 && ((i422 != 0) ? skp != 0 : skp == 0));
    fb = (f != 0) ? (pb + sb) / 2 : sb;
    fc = (f != 0) ? (pc + sc) / 2 : sc;
    {pb, pc} = {sb, sc};
    ob = (o422 == 0) ? sb : (oph != 0) ? fc : fb;
    if (o422 != 0) oph = 1 - oph;
    exp_q.push_back({la[11:0], ob[11:0], (o422 != 0) ? 12'h000 : sc[11:0]});
    chk_q.push_back(n >= 4);
  endtask

  task automatic run(input int byp, up, skp, i422, o422);
    int w;
    logic [35:0] e;
    wr(CFP_OFS_BYP, 8'(byp << CFP_BIT_BYP));
    wr(CFP_OFS_UP, 8'(up << CFP_BIT_UP));
    wr(CFP_OFS_SKIP, 8'(skp << CFP_BIT_SKIP));
    {ph, oph} = '0;
    // narrow widths only where no averaging hides the fill bits
    w = (byp != 0 && up == 0) ? $urandom_range(2) : 2;
    @(posedge i_core_clk);
    i_in_422 <= i422[0];
    i_out_422 <= o422[0];
    for (int n = 0; n < 12; n++) pix(w, up, byp, skp, i422, o422, n);
    @(posedge i_core_clk);
    i_vid_valid <= 1'b0;
    // formats stay until the last pixel has left stage 2
    repeat (2) @(posedge i_core_clk);
    i_in_422 <= 1'b0;
    i_out_422 <= 1'b0;
    repeat (2) @(posedge i_core_clk);
    `CHK("pixel count", exp_q.size(), u_cfp_sink.got.size());
    while (exp_q.size() > 0 && u_cfp_sink.got.size() > 0) begin
      e = exp_q.pop_front();
      if (chk_q.pop_front()) `CHK("o_vid_data", e, u_cfp_sink.got[0]);
      void'(u_cfp_sink.got.pop_front());
    end
    exp_q.delete();
    chk_q.delete();
  endtask

  function automatic logic [3:0] cs_exp(input int y, c, ec, q, yq, dvi);
    if (dvi != 0) return CFP_CS_RGB_LIM;
    if (y == 0) return (c == 3 && ec == 4) ? CFP_CS_ARGB : (q == 2) ? CFP_CS_RGB_FULL : 4'h0;
    if (c == 3) return (ec == 0) ? CFP_CS_XV601 : (ec == 1) ? CFP_CS_XV709 :
      (ec == 2) ? CFP_CS_SY601 : (ec == 3) ? CFP_CS_AYCC : CFP_CS_601;
    if (c == 2) return (yq == 1) ? CFP_CS_709F : CFP_CS_709;
    return (yq == 1) ? CFP_CS_601F : CFP_CS_601;
  endfunction

  initial begin
    #2_000_000;
    fail_count++;
    report_and_stop();
  end

  initial begin
    int y, c, ec, q, yq, dvi;
    void'($urandom(32'hbd51_e4d0));
    repeat (12) @(posedge i_core_clk);
    i_rst <= 1'b0;
    for (int k = 0; k < 4; k++) rd(ofs[k], (k == 1) ? 8'h10 : 8'h00);
    `CHK("o_cs_code", 4'h0, o_cs_code);
    for (int k = 0; k < 5; k++) wr(ofs[k], 8'hff);
    for (int k = 0; k < 5; k++) rd(ofs[k], keep[k]);
    for (int m = 0; m < 32; m++) run(m[4], m[3], m[2], m[1], m[0]);
    for (int k = 0; k < 48; k++) begin
      {y, c, q, yq} = {$urandom_range(3), $urandom_range(3), $urandom_range(3), $urandom_range(3)};
      ec = $urandom_range(7);
      dvi = (k % 8 == 7);
      @(posedge i_core_clk);
      {i_avi_valid, i_dvi_mode} <= {1'b1, dvi[0]};
      {i_avi_y, i_avi_c, i_avi_ec, i_avi_q, i_avi_yq} <= {y[1:0], c[1:0], ec[2:0], q[1:0], yq[1:0]};
      @(posedge i_core_clk);
      i_avi_valid <= 1'b0;
      #1;
      `CHK("o_cs_code", cs_exp(y, c, ec, q, yq, dvi), o_cs_code);
      rd(CFP_OFS_CS, {4'h0, cs_exp(y, c, ec, q, yq, dvi)});
    end
    report_and_stop();
  end
endmodule // tb_rx_video_chroma_format_path
